// ==== address_range_perf_counter_bench.sv ====
// Self-checking bench: register tasks, integer model of the counts and time.
// Assumes the target_cpu model drives the target side of the design.
module address_range_perf_counter_bench;
    import perf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic target_run = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rdat;
    logic bus_valid;
    logic [1:0] bus_cycle;
    logic [ADDR_W-1:0] bus_addr;
    logic pc_valid;
    logic [ADDR_W-1:0] pc_value;
    logic ext_clk;
    logic measuring;
    logic irq;
    logic [ADDR_W-1:0] a_lo, a_hi, b_lo, b_hi, x_ad;
    logic [1:0] md;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int cnt, tim, t0;
    bit timing, prev_b, last_a, exec_a, ext_m;
    perf_counter DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
        .bus_cycle(bus_cycle), .bus_addr(bus_addr), .pc_valid(pc_valid), .pc_value(pc_value),
        .target_run(target_run), .ext_clk(ext_clk), .measuring(measuring), .irq(irq));
    target_cpu tgt (.sys_clk(sys_clk), .bus_valid(bus_valid), .bus_cycle(bus_cycle),
        .bus_addr(bus_addr), .pc_valid(pc_valid), .pc_value(pc_value), .ext_clk(ext_clk));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rdat = reg_rdata;
        chk(rdat, exp);
    endtask : rchk
    function automatic bit inw(input logic [ADDR_W-1:0] ad, lo, hi);
        return (ad >= lo) && (ad <= hi);
    endfunction : inw
    task automatic exec(input logic [ADDR_W-1:0] ad);
        bit ia, ib;
        ia = inw(ad, a_lo, a_hi);
        ib = inw(ad, b_lo, b_hi);
        if (md == MODE_RANGE) begin
            if (ib && !prev_b) cnt++;
            if (timing && ib) begin
                timing = 0;
                tim += ext_m ? 0 : cyc - t0;
            end else if (!timing && ia && !ib) begin
                timing = 1;
                t0 = cyc;
            end
        end else if (md == MODE_CALL && ib && !prev_b && last_a) begin
            cnt++;
        end
        if (!ib) last_a = ia;
        prev_b = ib;
        tgt.pc(ad);
    endtask : exec
    task automatic acc(input logic [1:0] ct, input logic [ADDR_W-1:0] ad, input logic [1:0] at);
        if (ct == CYC_PREFETCH) exec_a = inw(ad, a_lo, a_hi);
        if (inw(ad, b_lo, b_hi) && exec_a && (at == ACC_ANY || at == ct + 2'h1)) cnt++;
        tgt.bus(ct, ad);
    endtask : acc
    task automatic run_begin(input logic [1:0] m, input bit src, input logic [1:0] rs,
                             input logic [1:0] at);
        md = m;
        cnt = 0;
        tim = 0;
        timing = 0;
        prev_b = 0;
        last_a = 0;
        exec_a = 0;
        wr(OFS_CTRL, {24'h0, at, rs, 1'b0, src, m});
        @(posedge sys_clk);
        target_run <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, measuring}, 32'h1);
    endtask : run_begin
    task automatic run_end();
        @(posedge sys_clk);
        target_run <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, measuring}, 32'h0);
        tgt.pc(b_lo);
        rchk(OFS_COUNT, DATA_W'(cnt));
        if (md == MODE_RANGE) rchk(OFS_TIME_LO, DATA_W'(tim));
        if (md == MODE_RANGE) rchk(OFS_TIME_HI, 32'h0);
        rchk(OFS_STATE, 32'h20);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STATUS, 32'h7);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        $display("test done mode %0d", md);
    endtask : run_end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        void'($urandom(32'h982f3bce));
        a_lo = $urandom & 32'h7fffff00;
        a_hi = a_lo + 32'h40;
        b_lo = a_lo + 32'h100;
        b_hi = b_lo + 32'h40;
        x_ad = a_lo + 32'h800;
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_STATE, 32'h0);
        wr(8'h2c, 32'h5a5a5a5a);
        rchk(8'h2c, 32'h0);
        wr(OFS_COUNT, 32'h12);
        rchk(OFS_COUNT, 32'h0);
        wr(OFS_A_START, a_lo);
        wr(OFS_A_END, a_hi);
        wr(OFS_B_START, b_lo);
        wr(OFS_B_END, b_hi);
        rchk(OFS_B_END, b_hi);
        wr(OFS_MASK, 32'h7);
        $display("test done registers");
        for (int r = 0; r < 4; r++) begin
            ext_m = (r == 3);
            run_begin(MODE_RANGE, 1'b0, r[1:0], ACC_ANY);
            exec(x_ad);
            exec(a_lo);
            repeat ($urandom_range(1, 6)) exec(x_ad);
            if (ext_m) begin
                tgt.ext_pulses(3);
                tim += 3;
            end
            exec(b_hi);
            exec(x_ad);
            exec(b_lo);
            exec(b_lo);
            exec(a_hi);
            exec(b_lo);
            run_end();
        end
        ext_m = 0;
        for (int t = 0; t < 4; t++) begin
            run_begin(MODE_ACCESS, 1'b1, RES_160, t[1:0]);
            acc(CYC_PREFETCH, a_lo, t[1:0]);
            acc(CYC_DATA, b_hi, t[1:0]);
            acc(CYC_XFER, b_lo, t[1:0]);
            acc(CYC_OTHER, b_lo, t[1:0]);
            acc(CYC_PREFETCH, x_ad, t[1:0]);
            acc(CYC_DATA, b_lo, t[1:0]);
            acc(CYC_PREFETCH, a_hi, t[1:0]);
            acc(CYC_PREFETCH, b_lo, t[1:0]);
            run_end();
        end
        run_begin(MODE_CALL, 1'b0, RES_160, ACC_ANY);
        exec(a_lo);
        exec(b_lo);
        exec(b_hi);
        exec(x_ad);
        exec(b_lo);
        exec(a_hi);
        exec(b_hi);
        run_end();
        run_begin(MODE_OFF, 1'b0, RES_160, ACC_ANY);
        exec(a_lo);
        exec(b_lo);
        run_end();
        end_of_test();
    end
endmodule : address_range_perf_counter_bench

// ==== perf_counter.sv ====
// Address range performance counter, one measurement channel.
// Assumes bus and program counter inputs are synchronous to sys_clk and that
// target_run is high while the target program executes.
module perf_counter
    import perf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic bus_valid,
    input wire logic [1:0] bus_cycle,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic pc_valid,
    input wire logic [ADDR_W-1:0] pc_value,
    input wire logic target_run,
    input wire logic ext_clk,
    output logic measuring,
    output logic irq
);

    tick_if tif ();

    logic [CTRL_W-1:0] ctrl_r;
    logic [ADDR_W-1:0] a_start_r;
    logic [ADDR_W-1:0] a_end_r;
    logic [ADDR_W-1:0] b_start_r;
    logic [ADDR_W-1:0] b_end_r;
    logic [TIME_W-1:0] time_r;
    logic [DATA_W-1:0] count_r;
    logic [STATUS_W-1:0] status_r;
    logic [STATUS_W-1:0] mask_r;
    logic time_ovf_r;
    logic run_d_r;
    logic in_a_r;
    logic in_b_r;
    logic last_a_r;
    meas_e state_r;
    meas_e state_nxt;
    logic [DATA_W-1:0] reg_rdata_r;
    logic irq_r;
    logic measuring_r;

    mode_e mode;
    res_e res_sel;
    acc_e acc_sel;
    logic src_prefetch;
    logic run_rise;
    logic run_fall;
    logic active;
    logic exec_valid;
    logic [ADDR_W-1:0] exec_addr;
    logic hit_a;
    logic hit_b;
    logic code_now;
    logic acc_hit;
    logic type_ok;
    logic start_hit;
    logic end_hit;
    logic end_entry;
    logic call_entry;
    logic count_inc;
    logic time_step;
    logic time_wrap;
    logic wr_status;
    logic [STATUS_W-1:0] status_set;

    tick_gen u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tif(tif)
    );

    assign mode = mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
    assign res_sel = res_e'(ctrl_r[CTRL_RES_LSB +: 2]);
    assign acc_sel = acc_e'(ctrl_r[CTRL_ATYPE_LSB +: 2]);
    assign src_prefetch = ctrl_r[CTRL_SRC_BIT];
    assign tif.res_sel = res_sel;
    assign tif.ext_clk = ext_clk;

    assign run_rise = target_run & ~run_d_r;
    assign run_fall = ~target_run & run_d_r;
    assign active = target_run && (state_r == MS_WAIT || state_r == MS_TIMING);

    always_comb begin
        if (src_prefetch) begin
            exec_valid = bus_valid && (bus_cycle == CYC_PREFETCH);
            exec_addr = bus_addr;
        end else begin
            exec_valid = pc_valid;
            exec_addr = pc_value;
        end
    end

    assign hit_a = in_window(exec_addr, a_start_r, a_end_r);
    assign hit_b = in_window(exec_addr, b_start_r, b_end_r);
    assign acc_hit = in_window(bus_addr, b_start_r, b_end_r);

    always_comb begin
        case (acc_sel)
            ACC_ANY: type_ok = 1'b1;
            ACC_PREFETCH: type_ok = (bus_cycle == CYC_PREFETCH);
            ACC_DATA: type_ok = (bus_cycle == CYC_DATA);
            ACC_XFER: type_ok = (bus_cycle == CYC_XFER);
            default: type_ok = 1'b0;
        endcase
    end

    assign start_hit = active && mode == MODE_RANGE && exec_valid && hit_a;
    assign end_hit = active && mode == MODE_RANGE && exec_valid && hit_b;
    // One count per pass through the end window
    assign end_entry = end_hit && !in_b_r;
    // Access counted while execution lies in the code window
    assign code_now = exec_valid ? hit_a : in_a_r;
    // Entry into subroutine window from caller window
    assign call_entry = active && mode == MODE_CALL && exec_valid && hit_b
        && !in_b_r && last_a_r;

    always_comb begin
        case (mode)
            MODE_RANGE: count_inc = end_entry;
            MODE_ACCESS: count_inc = active && bus_valid && acc_hit && type_ok && code_now;
            MODE_CALL: count_inc = call_entry;
            default: count_inc = 1'b0;
        endcase
    end

    // Time advances on each resolution tick while timing
    assign time_step = target_run && state_r == MS_TIMING && tif.tick;
    assign time_wrap = time_step && (&time_r);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MS_IDLE, MS_HOLD: begin
                if (run_rise) begin
                    state_nxt = MS_WAIT;
                end
            end
            MS_WAIT: begin
                if (!target_run) begin
                    state_nxt = MS_HOLD;
                end else if (start_hit && !end_hit) begin
                    state_nxt = MS_TIMING;
                end
            end
            MS_TIMING: begin
                if (!target_run) begin
                    state_nxt = MS_HOLD;
                end else if (end_hit) begin
                    state_nxt = MS_WAIT;
                end
            end
            default: state_nxt = MS_IDLE;
        endcase
    end

    // Measurement state, held after execution stops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= MS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= target_run;
        end
    end

    // Window residency of the last execution address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_a_r <= 1'b0;
            in_b_r <= 1'b0;
            last_a_r <= 1'b0;
        end else if (run_rise) begin
            in_a_r <= 1'b0;
            in_b_r <= 1'b0;
            last_a_r <= 1'b0;
        end else if (exec_valid) begin
            in_a_r <= hit_a;
            in_b_r <= hit_b;
            if (!hit_b) begin
                last_a_r <= hit_a;
            end
        end
    end

    // 40-bit time counter, cleared at execution start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            time_r <= '0;
        end else if (run_rise) begin
            time_r <= '0;
        end else if (time_step) begin
            time_r <= time_r + TIME_W'(1);
        end
    end

    // Overflow flag replaces the time result
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            time_ovf_r <= 1'b0;
        end else if (run_rise) begin
            time_ovf_r <= 1'b0;
        end else if (time_wrap) begin
            time_ovf_r <= 1'b1;
        end
    end

    // Event count cleared at execution start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (run_rise) begin
            count_r <= '0;
        end else if (count_inc) begin
            count_r <= count_r + DATA_W'(1);
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
            a_start_r <= '0;
            a_end_r <= '0;
            b_start_r <= '0;
            b_end_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: ctrl_r <= reg_wdata[CTRL_W-1:0];
                OFS_A_START: a_start_r <= reg_wdata;
                OFS_A_END: a_end_r <= reg_wdata;
                OFS_B_START: b_start_r <= reg_wdata;
                OFS_B_END: b_end_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_r <= '0;
        end else if (reg_wr && reg_addr == OFS_MASK) begin
            mask_r <= reg_wdata[STATUS_W-1:0];
        end
    end

    // Sticky events, write one to clear, a new event wins over the clear
    always_comb begin
        status_set = '0;
        status_set[ST_DONE] = run_fall;
        status_set[ST_OVF] = time_wrap;
        status_set[ST_EVENT] = count_inc;
    end

    assign wr_status = reg_wr && reg_addr == OFS_STATUS;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_r <= '0;
        end else if (wr_status) begin
            status_r <= (status_r & ~reg_wdata[STATUS_W-1:0]) | status_set;
        end else begin
            status_r <= status_r | status_set;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            measuring_r <= 1'b0;
        end else begin
            measuring_r <= (state_nxt == MS_WAIT || state_nxt == MS_TIMING);
        end
    end

    // Read data stand for the one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: reg_rdata_r <= DATA_W'(ctrl_r);
                OFS_A_START: reg_rdata_r <= a_start_r;
                OFS_A_END: reg_rdata_r <= a_end_r;
                OFS_B_START: reg_rdata_r <= b_start_r;
                OFS_B_END: reg_rdata_r <= b_end_r;
                OFS_TIME_LO: reg_rdata_r <= time_ovf_r ? TIME_OVF_MARK : time_r[DATA_W-1:0];
                OFS_TIME_HI: reg_rdata_r <= time_ovf_r ? TIME_OVF_MARK
                    : DATA_W'(time_r[TIME_W-1:DATA_W]);
                OFS_COUNT: reg_rdata_r <= count_r;
                OFS_STATUS: reg_rdata_r <= DATA_W'(status_r);
                OFS_MASK: reg_rdata_r <= DATA_W'(mask_r);
                OFS_STATE: begin
                    reg_rdata_r <= '0;
                    reg_rdata_r[STB_RUN] <= target_run;
                    reg_rdata_r[STB_TIMING] <= (state_r == MS_TIMING);
                    reg_rdata_r[STB_OVF] <= time_ovf_r;
                    reg_rdata_r[STB_FSM_LSB +: 2] <= state_r;
                end
                default: reg_rdata_r <= '0;
            endcase
        end else begin
            reg_rdata_r <= '0;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign irq = irq_r;
    assign measuring = measuring_r;

endmodule : perf_counter

// ==== perf_counter_properties.sv ====
// Concurrent checks on the ports of the performance counter.
// Assumes a single sys_clk domain; helper logic mirrors the written control, end window and mask registers.
module perf_counter_properties
    import perf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic pc_valid,
    input wire logic [ADDR_W-1:0] pc_value,
    input wire logic target_run,
    input wire logic measuring,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [CTRL_W-1:0] ctrl_r;
    logic [ADDR_W-1:0] blo_r;
    logic [ADDR_W-1:0] bhi_r;
    logic [STATUS_W-1:0] mask_r;
    logic prev_b_r;
    logic run_d_r;
    wire logic pc_in_b = pc_valid && (pc_value >= blo_r) && (pc_value <= bhi_r);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= '0;
            blo_r <= '0;
            bhi_r <= '0;
            mask_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: ctrl_r <= reg_wdata[CTRL_W-1:0];
                OFS_B_START: blo_r <= reg_wdata;
                OFS_B_END: bhi_r <= reg_wdata;
                OFS_MASK: mask_r <= reg_wdata[STATUS_W-1:0];
                default: ;
            endcase
        end
    end
    // Window history restarts with each run
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_b_r <= 1'b0;
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= target_run;
            if (target_run && !run_d_r) begin
                prev_b_r <= 1'b0;
            end else if (pc_valid) begin
                prev_b_r <= pc_in_b;
            end
        end
    end
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside read answer");
    a_unmapped_read: assert property (reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr > OFS_STATE)
        |=> reg_rdata == '0) else $error("unmapped read returned data");
    a_run_start_meas: assert property ($rose(target_run) |=> measuring)
        else $error("measuring did not start with run");
    a_run_stop_hold: assert property ($fell(target_run) |=> !measuring)
        else $error("measuring did not stop with run");
    a_idle_quiet: assert property (!$past(target_run) |-> !measuring)
        else $error("measuring while target stopped");
    a_done_irq: assert property ($fell(target_run) && mask_r[ST_DONE] |-> ##[1:3] irq)
        else $error("no interrupt after execution stop");
    a_end_event_irq: assert property (run_d_r && target_run && measuring && !prev_b_r && pc_in_b
        && ctrl_r[1:0] == MODE_RANGE && !ctrl_r[CTRL_SRC_BIT] && mask_r[ST_EVENT]
        |-> ##[1:3] irq)
        else $error("no count event on end window entry");
    a_irq_masked: assert property (mask_r == '0 && $past(mask_r) == '0 && $past(mask_r, 2) == '0
        |-> !irq) else $error("interrupt while fully masked");
    cover property ($rose(target_run));
    cover property (reg_rd && reg_addr == OFS_TIME_LO);
    cover property ($fell(irq));
endmodule : perf_counter_properties

bind perf_counter perf_counter_properties u_props (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pc_valid(pc_valid), .pc_value(pc_value),
    .target_run(target_run), .measuring(measuring), .irq(irq));

// ==== perf_pkg.sv ====
// Constants, types and helper functions for the address range performance counter.
// Assumes a single 10 MHz system clock and one measurement channel.
// Behaviour
// - Range mode: execution in start window starts timing, in end window stops it.
// - Range mode: each pass through the end window adds one to the count.
// - Access mode: count accesses to access window while executing in code window.
// - Access mode: qualify accesses by any, prefetch, data or transfer cycle.
// - Call mode: count entries into subroutine window from caller window.
// - Execution address comes from bus prefetch or from program counter.
// - Software selects 160ns, 40ns, 20ns or external clock resolution; at 100ns per cycle all three internal settings tick every cycle.
// - Time accumulates in a 40-bit counter, one step per tick.
// - Counter wrap is flagged as overflow instead of a valid time.
// - External resolution advances the counter once per rising input clock edge.
// - Start of target execution clears results and starts measuring.
// - Stop of target execution stops measuring and holds results.
package perf_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int TIME_W = 40;
    localparam int REG_AW = 8;
    localparam int DIV_W = 8;

    // Register byte offsets
    localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] OFS_A_START = 8'h04;
    localparam logic [REG_AW-1:0] OFS_A_END = 8'h08;
    localparam logic [REG_AW-1:0] OFS_B_START = 8'h0c;
    localparam logic [REG_AW-1:0] OFS_B_END = 8'h10;
    localparam logic [REG_AW-1:0] OFS_TIME_LO = 8'h14;
    localparam logic [REG_AW-1:0] OFS_TIME_HI = 8'h18;
    localparam logic [REG_AW-1:0] OFS_COUNT = 8'h1c;
    localparam logic [REG_AW-1:0] OFS_STATUS = 8'h20;
    localparam logic [REG_AW-1:0] OFS_MASK = 8'h24;
    localparam logic [REG_AW-1:0] OFS_STATE = 8'h28;

    // Control field layout
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_BIT = 2;
    localparam int CTRL_RES_LSB = 4;
    localparam int CTRL_ATYPE_LSB = 6;
    localparam int CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // Status and state bit positions
    localparam int ST_DONE = 0;
    localparam int ST_OVF = 1;
    localparam int ST_EVENT = 2;
    localparam int STATUS_W = 3;
    localparam int STB_RUN = 0;
    localparam int STB_TIMING = 1;
    localparam int STB_OVF = 2;
    localparam int STB_FSM_LSB = 4;

    localparam logic [DATA_W-1:0] TIME_OVF_MARK = 32'hffffffff;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_160_NS = 160;
    localparam int TICK_40_NS = 40;
    localparam int TICK_20_NS = 20;

    function automatic int ns_to_cycles(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles

    localparam logic [DIV_W-1:0] TICK_160_CYC = DIV_W'(ns_to_cycles(TICK_160_NS));
    localparam logic [DIV_W-1:0] TICK_40_CYC = DIV_W'(ns_to_cycles(TICK_40_NS));
    localparam logic [DIV_W-1:0] TICK_20_CYC = DIV_W'(ns_to_cycles(TICK_20_NS));

    typedef enum logic [1:0] {
        MODE_RANGE = 2'h0,
        MODE_ACCESS = 2'h1,
        MODE_CALL = 2'h2,
        MODE_OFF = 2'h3
    } mode_e;

    typedef enum logic [1:0] {
        RES_160 = 2'h0,
        RES_40 = 2'h1,
        RES_20 = 2'h2,
        RES_EXT = 2'h3
    } res_e;

    typedef enum logic [1:0] {
        ACC_ANY = 2'h0,
        ACC_PREFETCH = 2'h1,
        ACC_DATA = 2'h2,
        ACC_XFER = 2'h3
    } acc_e;

    // Bus cycle type reported with each valid bus cycle
    typedef enum logic [1:0] {
        CYC_PREFETCH = 2'h0,
        CYC_DATA = 2'h1,
        CYC_XFER = 2'h2,
        CYC_OTHER = 2'h3
    } cyc_e;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_WAIT = 2'b01,
        MS_TIMING = 2'b11,
        MS_HOLD = 2'b10
    } meas_e;

    function automatic logic in_window(input logic [ADDR_W-1:0] addr,
                                       input logic [ADDR_W-1:0] lo,
                                       input logic [ADDR_W-1:0] hi);
        return (addr >= lo) && (addr <= hi);
    endfunction : in_window

endpackage : perf_pkg

// ==== target_cpu.sv ====
// Model of the target processor: bus cycles, program counter and target clock.
// Assumes callers enter its tasks just after a rising sys_clk edge.
module target_cpu
    import perf_pkg::*;
(
    input wire logic sys_clk,
    output logic bus_valid,
    output logic [1:0] bus_cycle,
    output logic [ADDR_W-1:0] bus_addr,
    output logic pc_valid,
    output logic [ADDR_W-1:0] pc_value,
    output logic ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bus_valid = 1'b0;
        bus_cycle = CYC_OTHER;
        bus_addr = '0;
        pc_valid = 1'b0;
        pc_value = '0;
        ext_clk = 1'b0;
    end
    // Program counter source, stale value inverted
    task automatic pc(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        pc_valid <= 1'b1;
        pc_value <= a;
        @(posedge sys_clk);
        pc_valid <= 1'b0;
        pc_value <= ~a;
    endtask : pc
    // Typed bus cycle, stale value inverted
    task automatic bus(input logic [1:0] c, input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        bus_valid <= 1'b1;
        bus_cycle <= c;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_valid <= 1'b0;
        bus_cycle <= ~c;
        bus_addr <= ~a;
    endtask : bus
    // Target clock runs only on request
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ext_clk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            ext_clk <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : ext_pulses
endmodule : target_cpu

// ==== tick_gen.sv ====
// Resolution tick generator: internal divider or external clock edges.
// Assumes ext_clk is synchronous to sys_clk.
module tick_gen
    import perf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    tick_if.gen tif
);

    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] limit;
    logic ext_d_r;
    logic tick_r;

    always_comb begin
        case (tif.res_sel)
            RES_160: limit = TICK_160_CYC;
            RES_40: limit = TICK_40_CYC;
            RES_20: limit = TICK_20_CYC;
            default: limit = TICK_20_CYC;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= tif.ext_clk;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else if (tif.res_sel == RES_EXT || div_r >= limit - DIV_W'(1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else if (tif.res_sel == RES_EXT) begin
            tick_r <= tif.ext_clk & ~ext_d_r;
        end else begin
            tick_r <= (div_r >= limit - DIV_W'(1));
        end
    end

    assign tif.tick = tick_r;

endmodule : tick_gen

// ==== tick_if.sv ====
// Carries the resolution choice and external clock level to the tick generator.
// Assumes both ends run on sys_clk.
interface tick_if;
    logic [1:0] res_sel;
    logic ext_clk;
    logic tick;
    modport gen (input res_sel, input ext_clk, output tick);
    modport user (output res_sel, output ext_clk, input tick);
endinterface : tick_if
